// ### rtl/lrc_pkg.sv
// constants for the logical device resource configuration block
package lrc_pkg;

  // function slots
  localparam int NFN = 5;
  localparam int FN_FLOPPY = 0;
  localparam int FN_PP = 1;
  localparam int FN_UART1 = 2;
  localparam int FN_UART2 = 3;
  localparam int FN_KBD = 4;

  // logical device numbers, apb byte address = ldn<<10 | index<<2
  localparam int ADDR_W = 13;
  localparam logic [2:0] LDN_FLOPPY = 3'h0;
  localparam logic [2:0] LDN_GLOBAL = 3'h1;
  localparam logic [2:0] LDN_PP = 3'h3;
  localparam logic [2:0] LDN_UART1 = 3'h4;
  localparam logic [2:0] LDN_UART2 = 3'h5;
  localparam logic [2:0] LDN_KBD = 3'h7;

  // configuration register indices
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_POWER = 8'h31;
  localparam logic [7:0] IDX_BASE_HI = 8'h60;
  localparam logic [7:0] IDX_BASE_LO = 8'h61;
  localparam logic [7:0] IDX_IRQ = 8'h70;
  localparam logic [7:0] IDX_DMA = 8'h74;
  localparam logic [7:0] IDX_GCTRL = 8'h00;
  localparam logic [7:0] IDX_STATUS = 8'h01;

  // global control fields
  localparam int GCTRL_SERIRQ_BIT = 0;
  localparam int GCTRL_SMI_EN_BIT = 1;

  // reset values
  localparam logic [15:0] BASE_RST = 16'h0000;
  localparam logic [3:0] IRQ_RST = 4'h0;
  localparam logic [2:0] DMA_RST = 3'h4;
  localparam logic [1:0] GCTRL_RST = 2'h0;

  // base ranges and fixed decodes
  localparam logic [15:0] BASE_MIN = 16'h0100;
  localparam logic [15:0] BASE_MAX8 = 16'h0ff8;
  localparam logic [15:0] BASE_MAX4 = 16'h0ffc;
  localparam logic [11:0] ECP_OFS_FIFO = 12'h400;
  localparam logic [11:0] ECP_OFS_CNFGB = 12'h401;
  localparam logic [11:0] ECP_OFS_ECR = 12'h402;
  localparam logic [11:0] KBD_DATA_ADDR = 12'h060;
  localparam logic [11:0] KBD_CMD_ADDR = 12'h064;

  // extended control modes
  localparam logic [2:0] ECR_ECP = 3'h3;
  localparam logic [2:0] ECR_EPP = 3'h4;

  // interrupt levels usable in parallel mode: 3..7 and 10..12
  localparam logic [15:0] PAR_IRQ_MASK = 16'h1cf8;
  localparam logic [3:0] SMI_LEVEL = 4'h2;

endpackage

// ### rtl/lrc_top.sv
// logical device activation, base decode and irq/dma routing
// Contract
// - a function is on whenever its activate or power bit is set
// - activate and power bits are one linked bit, written through either
// - host cycles to a function with out-of-range base are ignored
// - only host address bits 11..0 are compared against each base
// - floppy and serial bases 0x100..0xff8, 8-aligned, eight offsets decoded
// - parallel port also decodes base+400h, +401h and +402h
// - keyboard is fixed at 60 and 64, not relocatable
// - interrupt level 0 means none, 1..15 selects that request line
// - interrupts are edge high, except parallel port in ecp or epp mode
// - level two carries the low-active management interrupt when it is on
// - interrupt needs nonzero level and the function's own enable
// - floppy interrupt and dma also need the floppy dma gate bit
// - parallel interrupt needs irq gate, and in ecp mode service mask clear
// - serial interrupt needs any interrupt enable and aux output two set
// - interrupt lines not selected by any active function float, except level two while the management interrupt is on
// - serial mode allows all levels, parallel mode only 3..7 and 10..12
// - dma field 0 reserved, 1..3 channels, 4..7 none, resets to 4
// - dma active only for channel 1..3 with the function's dma enable
// - second serial port dma also needs its infrared dma enable
// - dma request lines not selected by any active function float
// - index io_base_high holds base bits 15..8, io_base_low bits 7..0
// - floppy gate clear or floppy off floats its irq and ignores requests
module lrc_top (
  // apb clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [lrc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  // isa host pins
  input  wire logic [15:0]              isa_addr,
  input  wire logic                     isa_rd_n,
  input  wire logic                     isa_wr_n,
  // decoded host cycle to the functions
  output logic [4:0]                    fn_select,
  output logic [11:0]                   fn_offset,
  output logic                          fn_rd,
  output logic                          fn_wr,
  output logic                          pp_epp_allowed,
  // function state bits
  input  wire logic [4:0]               fn_irq_req,
  input  wire logic [4:0]               fn_dma_req,
  input  wire logic                     floppy_dma_gate,
  input  wire logic                     pp_irq_gate,
  input  wire logic                     ecp_service_mask,
  input  wire logic                     ecp_dma_gate,
  input  wire logic [2:0]               pp_ecr_mode,
  input  wire logic [3:0]               uart1_int_enables,
  input  wire logic                     uart1_aux_output_two,
  input  wire logic [3:0]               uart2_int_enables,
  input  wire logic                     uart2_aux_output_two,
  input  wire logic                     uart2_ir_dma_gate,
  input  wire logic                     sys_mgmt_event,
  // interrupt and dma pins, index is the level or channel-1
  output logic [15:1]                   irq_out,
  output logic [15:1]                   irq_oe,
  output logic                          irq_serial_mode,
  output logic [2:0]                    dma_request_out,
  output logic [2:0]                    dma_request_oe
);

  // ==========================================================
  // helpers
  // slot of a logical device number, bit 3 flags a valid slot
  function automatic logic [3:0] fn_slot(input logic [2:0] ldn);
    case (ldn)
      lrc_pkg::LDN_FLOPPY: fn_slot = {1'b1, 3'(lrc_pkg::FN_FLOPPY)};
      lrc_pkg::LDN_PP:     fn_slot = {1'b1, 3'(lrc_pkg::FN_PP)};
      lrc_pkg::LDN_UART1:  fn_slot = {1'b1, 3'(lrc_pkg::FN_UART1)};
      lrc_pkg::LDN_UART2:  fn_slot = {1'b1, 3'(lrc_pkg::FN_UART2)};
      lrc_pkg::LDN_KBD:    fn_slot = {1'b1, 3'(lrc_pkg::FN_KBD)};
      default:             fn_slot = 4'h0;
    endcase
  endfunction

  // which slots own a base register pair and a dma select
  function automatic logic has_base(input int s);
    has_base = (s != lrc_pkg::FN_KBD);
  endfunction

  function automatic logic has_dma(input int s);
    has_dma = (s == lrc_pkg::FN_FLOPPY) || (s == lrc_pkg::FN_PP) ||
              (s == lrc_pkg::FN_UART2);
  endfunction

  // ==========================================================
  // apb access decode
  logic [2:0] a_ldn;
  logic [7:0] a_idx;
  logic [3:0] a_slot;
  logic       wr_go;
  logic       setup;

  assign a_ldn  = paddr[12:10];
  assign a_idx  = paddr[9:2];
  assign a_slot = fn_slot(a_ldn);
  assign setup  = psel & ~penable & ~pready;
  assign wr_go  = psel & penable & pready & pwrite;

  // ==========================================================
  // configuration registers
  logic        active_q [lrc_pkg::NFN];
  logic [15:0] base_q   [lrc_pkg::NFN];
  logic [3:0]  irq_q    [lrc_pkg::NFN];
  logic [2:0]  dma_q    [lrc_pkg::NFN];
  logic [1:0]  gctrl_q;

  genvar gi;
  generate
    for (gi = 0; gi < lrc_pkg::NFN; gi++)
    begin : g_cfg
      logic sel_w;
      assign sel_w = wr_go & a_slot[3] & (a_slot[2:0] == 3'(gi));

      // one stored bit serves both activate and power control
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          active_q[gi] <= 1'b0;
        else if (sel_w && (a_idx == lrc_pkg::IDX_ACTIVATE ||
                           a_idx == lrc_pkg::IDX_POWER))
          active_q[gi] <= pwdata[0];
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          base_q[gi] <= lrc_pkg::BASE_RST;
        else if (sel_w && has_base(gi) && a_idx == lrc_pkg::IDX_BASE_HI)
          base_q[gi][15:8] <= pwdata[7:0];
        else if (sel_w && has_base(gi) && a_idx == lrc_pkg::IDX_BASE_LO)
          base_q[gi][7:0] <= pwdata[7:0];
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          irq_q[gi] <= lrc_pkg::IRQ_RST;
        else if (sel_w && a_idx == lrc_pkg::IDX_IRQ)
          irq_q[gi] <= pwdata[3:0];
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          dma_q[gi] <= lrc_pkg::DMA_RST;
        else if (sel_w && has_dma(gi) && a_idx == lrc_pkg::IDX_DMA)
          dma_q[gi] <= pwdata[2:0];
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gctrl_q <= lrc_pkg::GCTRL_RST;
    else if (wr_go && a_ldn == lrc_pkg::LDN_GLOBAL &&
             a_idx == lrc_pkg::IDX_GCTRL)
      gctrl_q <= pwdata[1:0];
  end

  // ==========================================================
  // apb read path and handshake
  logic [4:0]  active_vec;
  logic [7:0]  rd_d;
  logic        err_d;
  logic [2:0]  s;

  always_comb
  begin
    rd_d  = 8'h00;
    err_d = 1'b0;
    s     = a_slot[2:0];
    if (a_slot[3])
    begin
      case (a_idx)
        lrc_pkg::IDX_ACTIVATE,
        lrc_pkg::IDX_POWER:   rd_d = {7'h00, active_q[s]};
        lrc_pkg::IDX_BASE_HI: rd_d = base_q[s][15:8];
        lrc_pkg::IDX_BASE_LO: rd_d = base_q[s][7:0];
        lrc_pkg::IDX_IRQ:     rd_d = {4'h0, irq_q[s]};
        lrc_pkg::IDX_DMA:     rd_d = has_dma(int'(s)) ?
                                     {5'h00, dma_q[s]} : 8'h00;
        default:              rd_d = 8'h00;
      endcase
    end
    else if (a_ldn == lrc_pkg::LDN_GLOBAL)
    begin
      case (a_idx)
        lrc_pkg::IDX_GCTRL:  rd_d = {6'h00, gctrl_q};
        lrc_pkg::IDX_STATUS: rd_d = {2'h0, pp_epp_allowed, active_vec};
        default:             rd_d = 8'h00;
      endcase
    end
    else
      err_d = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      prdata  <= setup ? {24'h00_0000, rd_d} : 32'h0000_0000;
      pslverr <= setup & err_d;
    end
  end

  // ==========================================================
  // isa pin synchronisers, change taken once stages two and three agree
  logic [17:0] pin_s1_q;
  logic [17:0] pin_s2_q;
  logic [17:0] pin_s3_q;
  logic [17:0] pin_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_q <= 18'h3_0000;
      pin_s2_q <= 18'h3_0000;
      pin_s3_q <= 18'h3_0000;
      pin_q    <= 18'h3_0000;
    end
    else
    begin
      pin_s1_q <= {isa_rd_n, isa_wr_n, isa_addr};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (int b = 0; b < 18; b++)
        if (pin_s2_q[b] == pin_s3_q[b])
          pin_q[b] <= pin_s3_q[b];
    end
  end

  // ==========================================================
  // host address decode
  logic [11:0] ha;
  logic        h_rd;
  logic        h_wr;
  logic [4:0]  hit;
  logic [4:0]  in_range;
  logic [11:0] ofs [lrc_pkg::NFN];
  logic        pp_eight;

  assign ha   = pin_q[11:0];
  assign h_rd = ~pin_q[17];
  assign h_wr = ~pin_q[16];
  assign pp_eight = (base_q[lrc_pkg::FN_PP][2] == 1'b0);

  generate
    for (gi = 0; gi < lrc_pkg::NFN; gi++)
    begin : g_dec
      assign active_vec[gi] = active_q[gi];
      assign ofs[gi] = ha - base_q[gi][11:0];
    end
  endgenerate

  always_comb
  begin
    // 8-aligned relocatable functions
    for (int i = 0; i < lrc_pkg::NFN; i++)
    begin
      in_range[i] = (base_q[i] >= lrc_pkg::BASE_MIN) &&
                    (base_q[i] <= lrc_pkg::BASE_MAX8) &&
                    (base_q[i][2:0] == 3'h0);
      hit[i] = (ha[11:3] == base_q[i][11:3]);
    end
    // parallel port: 4-aligned base allowed, epp lost then
    in_range[lrc_pkg::FN_PP] = (base_q[lrc_pkg::FN_PP] >= lrc_pkg::BASE_MIN) &&
      (base_q[lrc_pkg::FN_PP] <= lrc_pkg::BASE_MAX4) &&
      (base_q[lrc_pkg::FN_PP][1:0] == 2'h0);
    hit[lrc_pkg::FN_PP] =
      (pp_eight ? (ha[11:3] == base_q[lrc_pkg::FN_PP][11:3])
                : (ha[11:2] == base_q[lrc_pkg::FN_PP][11:2])) ||
      (ofs[lrc_pkg::FN_PP] == lrc_pkg::ECP_OFS_FIFO) ||
      (ofs[lrc_pkg::FN_PP] == lrc_pkg::ECP_OFS_CNFGB) ||
      (ofs[lrc_pkg::FN_PP] == lrc_pkg::ECP_OFS_ECR);
    // keyboard sits at fixed addresses
    in_range[lrc_pkg::FN_KBD] = 1'b1;
    hit[lrc_pkg::FN_KBD] = (ha == lrc_pkg::KBD_DATA_ADDR) ||
                           (ha == lrc_pkg::KBD_CMD_ADDR);
  end

  logic [4:0] sel_d;
  logic [11:0] ofs_d;

  always_comb
  begin
    sel_d = 5'h00;
    ofs_d = 12'h000;
    for (int i = 0; i < lrc_pkg::NFN; i++)
      if ((h_rd || h_wr) && active_q[i] && in_range[i] && hit[i])
      begin
        sel_d[i] = 1'b1;
        ofs_d    = (i == lrc_pkg::FN_KBD) ? ha : ofs[i];
      end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fn_select      <= 5'h00;
      fn_offset      <= 12'h000;
      fn_rd          <= 1'b0;
      fn_wr          <= 1'b0;
      pp_epp_allowed <= 1'b0;
    end
    else
    begin
      fn_select      <= sel_d;
      fn_offset      <= ofs_d;
      fn_rd          <= h_rd & (|sel_d);
      fn_wr          <= h_wr & (|sel_d);
      pp_epp_allowed <= in_range[lrc_pkg::FN_PP] & pp_eight;
    end
  end

  // ==========================================================
  // interrupt routing
  logic [4:0] irq_cond;
  logic [4:0] irq_low;
  logic [15:1] irq_d;
  logic [15:1] irq_oe_d;
  logic [15:0] lvl_ok;
  logic        pp_ecp;
  logic        pp_epp;

  assign pp_ecp = (pp_ecr_mode == lrc_pkg::ECR_ECP);
  assign pp_epp = (pp_ecr_mode == lrc_pkg::ECR_EPP);
  assign lvl_ok = gctrl_q[lrc_pkg::GCTRL_SERIRQ_BIT] ? 16'hffff
                                                     : lrc_pkg::PAR_IRQ_MASK;

  always_comb
  begin
    irq_cond = active_vec;
    irq_cond[lrc_pkg::FN_FLOPPY] = active_q[lrc_pkg::FN_FLOPPY] &
                                   floppy_dma_gate;
    irq_cond[lrc_pkg::FN_PP] = active_q[lrc_pkg::FN_PP] & pp_irq_gate &
                               ~(pp_ecp & ecp_service_mask);
    irq_cond[lrc_pkg::FN_UART1] = active_q[lrc_pkg::FN_UART1] &
      (|uart1_int_enables) & uart1_aux_output_two;
    irq_cond[lrc_pkg::FN_UART2] = active_q[lrc_pkg::FN_UART2] &
      (|uart2_int_enables) & uart2_aux_output_two;
    irq_low = 5'h00;
    irq_low[lrc_pkg::FN_PP] = pp_ecp | pp_epp;
    irq_d    = '0;
    irq_oe_d = '0;
    for (int l = 1; l < 16; l++)
      for (int i = 0; i < lrc_pkg::NFN; i++)
        if (irq_cond[i] && irq_q[i] == 4'(l) && lvl_ok[l])
        begin
          irq_oe_d[l] = 1'b1;
          irq_d[l]    = irq_d[l] | (fn_irq_req[i] ^ irq_low[i]);
        end
    // the management interrupt owns level two while enabled
    if (gctrl_q[lrc_pkg::GCTRL_SMI_EN_BIT])
    begin
      irq_oe_d[lrc_pkg::SMI_LEVEL] = 1'b1;
      irq_d[lrc_pkg::SMI_LEVEL]    = ~sys_mgmt_event;
    end
  end

  // ==========================================================
  // dma routing
  logic [4:0] dma_cond;
  logic [2:0] drq_d;
  logic [2:0] drq_oe_d;

  always_comb
  begin
    dma_cond = 5'h00;
    dma_cond[lrc_pkg::FN_FLOPPY] = active_q[lrc_pkg::FN_FLOPPY] &
                                   floppy_dma_gate;
    dma_cond[lrc_pkg::FN_PP] = active_q[lrc_pkg::FN_PP] & ecp_dma_gate;
    dma_cond[lrc_pkg::FN_UART2] = active_q[lrc_pkg::FN_UART2] &
                                  uart2_ir_dma_gate;
    drq_d    = 3'h0;
    drq_oe_d = 3'h0;
    for (int c = 0; c < 3; c++)
      for (int i = 0; i < lrc_pkg::NFN; i++)
        if (dma_cond[i] && dma_q[i] == 3'(c + 1))
        begin
          drq_oe_d[c] = 1'b1;
          drq_d[c]    = drq_d[c] | fn_dma_req[i];
        end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_out         <= '0;
      irq_oe          <= '0;
      irq_serial_mode <= 1'b0;
      dma_request_out <= 3'h0;
      dma_request_oe  <= 3'h0;
    end
    else
    begin
      irq_out         <= irq_d;
      irq_oe          <= irq_oe_d;
      irq_serial_mode <= gctrl_q[lrc_pkg::GCTRL_SERIRQ_BIT];
      dma_request_out <= drq_d;
      dma_request_oe  <= drq_oe_d;
    end
  end

endmodule

// ### sim/lrc_chk.sv
// port assertions for the resource configuration block
module lrc_chk (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // host decode
  input wire logic        isa_rd_n,
  input wire logic [4:0]  fn_select,
  input wire logic [11:0] fn_offset,
  input wire logic        fn_rd,
  input wire logic        fn_wr,
  // interrupt routing
  input wire logic [15:1] irq_oe,
  input wire logic        irq_serial_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] bad_lvl;
  // levels barred in parallel mode
  assign bad_lvl = {irq_oe, 1'b0} & ~(lrc_pkg::PAR_IRQ_MASK | 16'h0004);
  // ==========================================
  // apb answer
  chk_ready_after_setup: assert property (
    psel && !penable |=> pready)
    else $error("no pready after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready too long");
  chk_err_with_ready: assert property (
    pslverr |-> pready && penable)
    else $error("pslverr off access");
  // ==========================================
  // host decode
  chk_sel_one_hot: assert property (
    (fn_rd || fn_wr) |-> $onehot(fn_select))
    else $error("select not one-hot");
  chk_host_strobe: assert property (
    $rose(fn_rd) |-> $past(isa_rd_n, 2) == 1'b0)
    else $error("read without strobe");
  chk_kbd_fixed: assert property (
    fn_select[4] |-> fn_offset inside {12'h060, 12'h064})
    else $error("keyboard off fixed ports");
  chk_base_span: assert property (
    |{fn_select[3:2], fn_select[0]} |-> fn_offset < 12'h008)
    else $error("offset past eight");
  chk_pp_span: assert property (
    fn_select[1] |-> fn_offset < 12'h008 ||
      fn_offset inside {[12'h400:12'h402]})
    else $error("parallel offset out of window");
  // ==========================================
  // interrupt levels
  chk_par_levels: assert property (
    !irq_serial_mode [*3] |-> bad_lvl == 16'h0000)
    else $error("barred level driven");
endmodule

bind lrc_top lrc_chk i_lrc_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .isa_rd_n(isa_rd_n),
  .fn_select(fn_select), .fn_offset(fn_offset), .fn_rd(fn_rd),
  .fn_wr(fn_wr), .irq_oe(irq_oe), .irq_serial_mode(irq_serial_mode)
);

// ### sim/lrc_isa_host.sv
// isa host model: runs host cycles and sees the request lines
module lrc_isa_host (
  // clock
  input wire logic         pclk,
  // host cycle pins
  output logic [15:0]      isa_addr,
  output logic             isa_rd_n,
  output logic             isa_wr_n,
  // request pins from the block
  input wire logic [15:1]  irq_out,
  input wire logic [15:1]  irq_oe,
  input wire logic [2:0]   dma_request_out,
  input wire logic [2:0]   dma_request_oe,
  // lines as the interrupt and dma controllers see them
  output wire logic [15:1] irq_line,
  output wire logic [2:0]  dma_line
);
  for (genvar i = 1; i < 16; i++)
  begin : g_irq
    assign irq_line[i] = irq_oe[i] ? irq_out[i] : 1'bz;
  end
  for (genvar j = 0; j < 3; j++)
  begin : g_dma
    assign dma_line[j] = dma_request_oe[j] ? dma_request_out[j] : 1'bz;
  end
  initial
  begin
    isa_addr = 16'h0000;
    isa_rd_n = 1'b1;
    isa_wr_n = 1'b1;
  end
  task automatic host_start(input logic [15:0] a, input logic w);
    @(posedge pclk);
    isa_addr <= a;
    isa_rd_n <= w;
    isa_wr_n <= !w;
  endtask
  task automatic host_end();
    @(posedge pclk);
    isa_rd_n <= 1'b1;
    isa_wr_n <= 1'b1;
    isa_addr <= ~isa_addr;
  endtask
endmodule

// ### sim/logical_device_resource_config_tb.sv
// self-checking bench for the resource configuration block
module logical_device_resource_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] LF  = lrc_pkg::LDN_FLOPPY;
  localparam logic [2:0] LP  = lrc_pkg::LDN_PP;
  localparam logic [2:0] LU1 = lrc_pkg::LDN_UART1;
  localparam logic [2:0] LU2 = lrc_pkg::LDN_UART2;
  localparam logic [2:0] LG  = lrc_pkg::LDN_GLOBAL;
  localparam logic [7:0] XA  = lrc_pkg::IDX_ACTIVATE;
  localparam logic [7:0] XI  = lrc_pkg::IDX_IRQ;
  localparam logic [7:0] XD  = lrc_pkg::IDX_DMA;
  localparam logic [7:0] XG  = lrc_pkg::IDX_GCTRL;
  logic                       pclk, presetn, psel, penable, pwrite;
  logic [lrc_pkg::ADDR_W-1:0] paddr;
  logic [31:0]                pwdata, prdata;
  logic                       pready, pslverr, pp_epp_allowed;
  logic [15:0]                isa_addr;
  logic                       isa_rd_n, isa_wr_n, fn_rd, fn_wr;
  logic [4:0]                 fn_select, fn_irq_req, fn_dma_req;
  logic [11:0]                fn_offset;
  logic                       floppy_dma_gate, pp_irq_gate, ecp_service_mask;
  logic [2:0]                 pp_ecr_mode, dma_request_out, dma_request_oe;
  logic [3:0]                 uart1_int_enables, uart2_int_enables;
  logic                       uart1_aux_output_two, uart2_aux_output_two;
  logic                       uart2_ir_dma_gate, sys_mgmt_event;
  logic [15:1]                irq_out, irq_oe;
  logic                       irq_serial_mode, err, ecp_dma_gate;
  wire  [15:1]                irq_line;
  wire  [2:0]                 dma_line;
  logic [7:0]                 rd;
  int                         n_fail, comparisons;

  lrc_top i_lrc_top (.*);
  lrc_isa_host i_lrc_isa_host (.*);

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ==========================================
  // checking and closing
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // apb master
  task automatic apb(input logic w, input logic [2:0] ld,
                     input logic [7:0] ix, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {ld, ix, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1)
    begin
      n_fail++;
      report_and_stop();
    end
    rd = prdata[7:0];
    err = pslverr;
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [2:0] ld, input logic [7:0] ix, d);
    apb(1'b1, ld, ix, d);
  endtask
  task automatic rchk(string nm, logic [2:0] ld, logic [7:0] ix, exp);
    apb(1'b0, ld, ix, 8'h00);
    chk(nm, rd, exp);
  endtask
  task automatic setup_fn(logic [2:0] ld, logic [15:0] b, logic [7:0] on);
    wr(ld, lrc_pkg::IDX_BASE_HI, b[15:8]);
    wr(ld, lrc_pkg::IDX_BASE_LO, b[7:0]);
    wr(ld, XA, on);
  endtask
  // ==========================================
  // host cycle and line checks
  task automatic host(logic [15:0] a, logic w, logic [4:0] s, logic [11:0] o);
    i_lrc_isa_host.host_start(a, w);
    repeat (8) @(negedge pclk);
    chk("fn_select", fn_select, s);
    if (s != 5'h00)
    begin
      chk("fn_offset", fn_offset, o);
      chk("fn_rd", fn_rd, !w);
      chk("fn_wr", fn_wr, w);
    end
    i_lrc_isa_host.host_end();
    repeat (8) @(negedge pclk);
  endtask
  task automatic route(int lv = 0, logic v = 1'b0,
                       int ch = 0, logic dv = 1'b0);
    logic [15:0] e;
    logic [3:0]  f;
    repeat (4) @(negedge pclk);
    e = 'z;
    f = 'z;
    if (lv > 0)
      e[lv] = v;
    if (ch > 0 && ch < 4)
      f[ch] = dv;
    chk("irq_line", irq_line, e[15:1]);
    chk("dma_line", dma_line, f[3:1]);
    @(posedge pclk);
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    logic [15:0] b;
    logic [11:0] o;
    logic [2:0]  ld;
    int          lv;
    n_fail = 0;
    comparisons = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata, fn_irq_req, fn_dma_req,
     floppy_dma_gate, pp_irq_gate, ecp_service_mask, ecp_dma_gate,
     pp_ecr_mode, uart1_int_enables, uart2_int_enables, uart1_aux_output_two,
     uart2_aux_output_two, uart2_ir_dma_gate, sys_mgmt_event} = '0;
    void'($urandom(84));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk("base_high", LF, lrc_pkg::IDX_BASE_HI, 8'h00);
    rchk("irq_level", LF, XI, 8'h00);
    rchk("dma_select", LP, XD, 8'h04);
    route();
    apb(1'b1, 3'h6, XA, 8'h01);
    chk("pslverr", err, 1'b1);
    wr(LF, lrc_pkg::IDX_POWER, 8'h01);
    rchk("activate", LF, XA, 8'h01);
    rchk("status", LG, lrc_pkg::IDX_STATUS, 8'h01);
    wr(LF, XA, 8'h00);
    rchk("power", LF, lrc_pkg::IDX_POWER, 8'h00);
    setup_fn(LF, 16'h03f0, 8'h01);
    rchk("base_low", LF, lrc_pkg::IDX_BASE_LO, 8'hf0);
    host(16'h03f2, 1'b0, 5'h01, 12'h002);
    host(16'hb3f7, 1'b1, 5'h01, 12'h007);
    host(16'h03f8, 1'b0, 5'h00, 12'h000);
    setup_fn(LF, 16'h00f8, 8'h01);
    host(16'h00fa, 1'b0, 5'h00, 12'h000);
    for (int i = 0; i < 4; i++)
    begin
      ld = i[0] ? LU2 : LU1;
      b = 16'h0100 + 16'($urandom_range(0, 16'h01df)) * 16'h0008;
      if (i > 1)
        b = i[0] ? lrc_pkg::BASE_MAX8 : lrc_pkg::BASE_MIN;
      o = 12'($urandom_range(0, 7));
      setup_fn(ld, b, 8'h01);
      host(b + 16'(o), i[1], 5'h04 << i[0], o);
      setup_fn(ld, b, 8'h00);
    end
    setup_fn(LP, 16'h037c, 8'h01);
    host(16'h077e, 1'b0, 5'h02, 12'h402);
    chk("epp_allowed", pp_epp_allowed, 1'b0);
    setup_fn(LP, 16'h0378, 8'h01);
    host(16'h0779, 1'b1, 5'h02, 12'h401);
    chk("epp_allowed", pp_epp_allowed, 1'b1);
    wr(lrc_pkg::LDN_KBD, XA, 8'h01);
    host(16'h0064, 1'b0, 5'h10, 12'h064);
    host(16'h0060, 1'b1, 5'h10, 12'h060);
    host(16'h0061, 1'b0, 5'h00, 12'h000);
    setup_fn(LU1, 16'h02f8, 8'h01);
    wr(LG, XG, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      lv = (i < 2) ? i : $urandom_range(3, 15);
      wr(LU1, XI, 8'(lv));
      @(posedge pclk);
      uart1_int_enables <= (i == 2) ? 4'h0 : 4'($urandom);
      uart1_aux_output_two <= (i == 3) ? 1'b0 : 1'($urandom);
      fn_irq_req <= {2'b00, 1'($urandom), 2'b00};
      @(posedge pclk);
      if (uart1_int_enables == 4'h0 || !uart1_aux_output_two)
        lv = 0;
      route(lv, fn_irq_req[2], 0, 1'b0);
    end
    uart1_int_enables <= 4'h8;
    uart1_aux_output_two <= 1'b1;
    fn_irq_req <= 5'h04;
    wr(LG, XG, 8'h00);
    wr(LU1, XI, 8'h09);
    route();
    wr(LU1, XI, 8'h0c);
    route(12, 1'b1, 0, 1'b0);
    wr(LU1, XI, 8'h00);
    sys_mgmt_event <= 1'b1;
    wr(LG, XG, 8'h03);
    route(2, 1'b0, 0, 1'b0);
    sys_mgmt_event <= 1'b0;
    route(2, 1'b1, 0, 1'b0);
    wr(LG, XG, 8'h01);
    wr(LU1, XI, 8'h02);
    route(2, 1'b1, 0, 1'b0);
    wr(LU1, XI, 8'h00);
    wr(LP, XI, 8'h07);
    @(posedge pclk);
    fn_irq_req <= 5'h02;
    pp_irq_gate <= 1'b1;
    route(7, 1'b1, 0, 1'b0);
    pp_ecr_mode <= lrc_pkg::ECR_ECP;
    route(7, 1'b0, 0, 1'b0);
    ecp_service_mask <= 1'b1;
    route();
    pp_ecr_mode <= lrc_pkg::ECR_EPP;
    route(7, 1'b0, 0, 1'b0);
    pp_irq_gate <= 1'b0;
    route();
    setup_fn(LF, 16'h03f0, 8'h01);
    wr(LF, XI, 8'h06);
    @(posedge pclk);
    fn_irq_req <= 5'h01;
    fn_dma_req <= 5'h01;
    floppy_dma_gate <= 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      wr(LF, XD, 8'(c));
      route(6, 1'b1, c, 1'b1);
    end
    wr(LF, XD, 8'h02);
    floppy_dma_gate <= 1'b0;
    route();
    floppy_dma_gate <= 1'b1;
    wr(LF, XA, 8'h00);
    route();
    wr(LP, XD, 8'h01);
    fn_dma_req <= 5'h02;
    route();
    ecp_dma_gate <= 1'b1;
    route(0, 1'b0, 1, 1'b1);
    ecp_dma_gate <= 1'b0;
    setup_fn(LU2, 16'h02e8, 8'h01);
    wr(LU2, XD, 8'h03);
    fn_dma_req <= 5'h08;
    route();
    uart2_ir_dma_gate <= 1'b1;
    route(0, 1'b0, 3, 1'b1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk("dma_after_reset", LU2, XD, 8'h04);
    route();
    report_and_stop();
  end
endmodule
